// [acr_top.sv]
// Converter control registers, clocking and APB slave
`timescale 1ns/10ps
`default_nettype none
module acr_top
  import acr_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             halt_mode,
  input  wire logic             wait_mode,
  input  wire logic             cmp_above,
  output logic                  converter_power,
  output logic [CH_W-1:0]       mux_channel,
  output logic                  amp_path_select,
  output logic                  amp_offset_cal,
  output logic [RES_W-1:0]      dac_code,
  output logic                  irq
);

  // ==========================================================
  // Declarations
  logic                 converter_on;
  logic                 speed;
  logic                 slow;
  logic [CH_W-1:0]      channel_select;
  logic                 eoc;
  logic [RES_W-1:0]     result;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  logic [SETTLE_W-1:0]  settle_cnt;
  logic                 halt_q;
  logic                 cmp_meta;
  logic                 cmp_sync;
  logic [1:0]           div_cnt;
  logic [1:0]           div_lim;
  logic                 tick;
  logic                 run;
  logic                 restart;
  logic                 sar_done;
  logic                 sar_busy;
  logic [RES_W-1:0]     sar_result;
  logic                 access;
  logic                 setup_rd;
  logic                 wr;
  logic                 rd;
  logic [9:0]           idx;
  logic                 mapped;
  logic                 wr_csr;
  logic                 wr_drl;
  logic                 wr_ist;
  logic                 wr_imsk;
  logic                 rd_drh;
  logic [7:0]           wbyte;
  logic [7:0]           rd_data;
  logic                 conv_done;
  logic [IRQ_W-1:0]     irq_event;
  logic [IRQ_W-1:0]     next_irq_status;

  // ==========================================================
  // APB decode
  // Registers sit on aligned words; bits above 7 read zero
  assign idx      = paddr[11:2];
  assign mapped   = (paddr[1:0] == 2'h0) &&
                    ((idx == CSR_IDX) || (idx == DRH_IDX) ||
                     (idx == DRL_IDX) || (idx == IST_IDX) ||
                     (idx == IMSK_IDX) || (idx == STAT_IDX));
  assign setup_rd = psel && penable && !pready;
  assign access   = psel && penable && pready;
  assign wr       = access && pwrite && mapped;
  assign rd       = access && !pwrite && mapped;
  assign wbyte    = pwdata[7:0];
  assign wr_csr   = wr && (idx == CSR_IDX);
  assign wr_drl   = wr && (idx == DRL_IDX);
  assign wr_ist   = wr && (idx == IST_IDX);
  assign wr_imsk  = wr && (idx == IMSK_IDX);
  assign rd_drh   = rd && (idx == DRH_IDX);

  // ==========================================================
  // Read mux
  always_comb begin
    rd_data = 8'h00;
    if (paddr[1:0] == 2'h0) begin
      unique case (idx)
        CSR_IDX: begin
          // Bit 4 is reserved and reads zero
          rd_data = {eoc, speed, converter_on, 1'b0, channel_select};
        end
        DRH_IDX: begin
          rd_data = result[RES_W-1:2];
        end
        DRL_IDX: begin
          rd_data = {3'h0, amp_offset_cal, slow, amp_path_select,
                     result[1:0]};
        end
        IST_IDX: begin
          rd_data = {6'h00, irq_status};
        end
        IMSK_IDX: begin
          rd_data = {6'h00, irq_mask};
        end
        STAT_IDX: begin
          rd_data = {4'h0, wait_mode, (settle_cnt != '0), halt_mode,
                     sar_busy};
        end
        default: begin
          rd_data = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // APB answer: one wait state, data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_rd;
      pslverr <= setup_rd && !mapped;
      if (setup_rd && !pwrite && mapped) begin
        prdata <= {24'h00_0000, rd_data};
      end else if (setup_rd) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on   <= 1'b0;
      speed          <= 1'b0;
      channel_select <= CH_RST;
    end else if (wr_csr) begin
      converter_on   <= wbyte[CSR_ON];
      speed          <= wbyte[CSR_SPEED];
      // Inputs past nine depend on the package; value is kept as written
      channel_select <= wbyte[CH_W-1:0];
    end
  end

  // ==========================================================
  // Low control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_offset_cal  <= 1'b0;
      slow            <= 1'b0;
      amp_path_select <= 1'b0;
    end else if (wr_drl) begin
      amp_offset_cal  <= wbyte[DRL_CAL];
      slow            <= wbyte[DRL_SLOW];
      amp_path_select <= wbyte[DRL_AMP];
    end
  end

  // ==========================================================
  // Converter enable
  // Wait mode is deliberately absent here
  assign run     = converter_on && !halt_mode;
  assign restart = wr_csr && (wbyte[CH_W-1:0] != channel_select);
  // A finish that collides with an abort is discarded
  assign conv_done = sar_done && !restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_power <= 1'b0;
      mux_channel     <= CH_RST;
    end else begin
      converter_power <= run;
      mux_channel     <= wr_csr ? wbyte[CH_W-1:0] : channel_select;
    end
  end

  // ==========================================================
  // Converter clock divider
  // Clock limits for the amplifier path are left to software
  always_comb begin
    if (slow) begin
      div_lim = DIV_QUART;
    end else if (speed) begin
      div_lim = DIV_FULL;
    end else begin
      div_lim = DIV_HALF;
    end
  end

  assign tick = (div_cnt >= div_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
    end else if (!run || tick) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // ==========================================================
  // Comparator synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_above;
      cmp_sync <= cmp_meta;
    end
  end

  // ==========================================================
  // Sequencer
  acr_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .restart  (restart),
    .tick     (tick),
    .cmp_hi   (cmp_sync),
    .dac_code (dac_code),
    .result   (sar_result),
    .done     (sar_done),
    .busy     (sar_busy)
  );

  // ==========================================================
  // Result and done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (conv_done) begin
      result <= sar_result;
    end
  end

  // Completion wins over a read or write clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc <= 1'b0;
    end else if (conv_done) begin
      eoc <= 1'b1;
    end else if (rd_drh || wr_csr) begin
      eoc <= 1'b0;
    end
  end

  // ==========================================================
  // Settling after halt wakeup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q     <= 1'b0;
      settle_cnt <= '0;
    end else begin
      halt_q <= halt_mode;
      if (halt_q && !halt_mode) begin
        settle_cnt <= SETTLE_W'(SETTLE_CYC);
      end else if (halt_mode) begin
        settle_cnt <= '0;
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - SETTLE_W'(1);
      end
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  // Masks reset to zero, so by default only polling is used
  assign irq_event = {restart && sar_busy, conv_done};

  always_comb begin
    next_irq_status = irq_status;
    if (wr_ist) begin
      next_irq_status = irq_status & ~wbyte[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= IMSK_RST;
    end else if (wr_imsk) begin
      irq_mask <= wbyte[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule : acr_top
`default_nettype wire

// [acr_pkg.sv]
// Constants shared by the converter control block and its sequencer
// How it works
// - Clearing converter_on powers the converter down and stops conversions.
// - The wait low-power mode has no effect on the converter.
// - Halt disables the converter; a settling flag runs after wakeup.
// - Done flag sets on completion; clears on result_high read or control write.
// - Converter clock: slow gives cpu/4, else speed gives cpu, else cpu/2.
// - Converter_on is read/write; one switches on, zero switches off.
// - Four-bit channel_select picks analog input zero to nine.
// - Result_high shows result bits nine down to two.
// - The two low result bits sit in bits 1:0 of result_low_control.
// - Bits 7:5 of result_low_control always read zero.
// - Amp_offset_cal ties the amplifier input to zero volts.
// - Amp_path_select routes the input through the amplifier when set.
// - Once switched on, the selected channel converts continuously.
// - A channel change aborts the conversion, clears done and restarts.
// - Input above reference gives all ones; below gives all zeros.
package acr_pkg;

  // ==========================================================
  // Register map (index; byte address is four times the index)
  localparam logic [9:0] CSR_IDX  = 10'h036;
  localparam logic [9:0] DRH_IDX  = 10'h037;
  localparam logic [9:0] DRL_IDX  = 10'h038;
  localparam logic [9:0] IST_IDX  = 10'h039;
  localparam logic [9:0] IMSK_IDX = 10'h03A;
  localparam logic [9:0] STAT_IDX = 10'h03B;

  // ==========================================================
  // Field positions
  localparam int unsigned CSR_EOC   = 7;
  localparam int unsigned CSR_SPEED = 6;
  localparam int unsigned CSR_ON    = 5;
  localparam int unsigned CH_W      = 4;
  localparam int unsigned DRL_CAL   = 4;
  localparam int unsigned DRL_SLOW  = 3;
  localparam int unsigned DRL_AMP   = 2;
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_ABORT = 1;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_HALT   = 1;
  localparam int unsigned ST_SETTLE = 2;
  localparam int unsigned ST_WAIT   = 3;

  // ==========================================================
  // Reset values
  localparam logic [3:0]       CH_RST   = 4'h0;
  localparam logic [IRQ_W-1:0] IMSK_RST = 2'h0;

  // ==========================================================
  // Result and timing
  localparam int unsigned RES_W      = 10;
  localparam logic [3:0]  SAR_MSB    = 4'h9;
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned SETTLE_NS  = 10000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W   = 12;
  localparam logic [1:0]  CMP_WAIT   = 2'h3;
  localparam logic [1:0]  DIV_FULL   = 2'h0;
  localparam logic [1:0]  DIV_HALF   = 2'h1;
  localparam logic [1:0]  DIV_QUART  = 2'h3;

  typedef enum logic [1:0] {
    ACR_SAR_IDLE   = 2'b00,
    ACR_SAR_SAMPLE = 2'b01,
    ACR_SAR_TRIAL  = 2'b10
  } acr_sar_e;

endpackage : acr_pkg

// [acr_sar.sv]
// Successive-approximation sequencer stepping on converter clock ticks
`timescale 1ns/10ps
`default_nettype none
module acr_sar
  import acr_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic             tick,
  input  wire logic             cmp_hi,
  output logic [RES_W-1:0]      dac_code,
  output logic [RES_W-1:0]      result,
  output logic                  done,
  output logic                  busy
);

  acr_sar_e         state;
  logic [3:0]       idx;
  logic [1:0]       lat;
  logic [RES_W-1:0] bit_mask;
  logic [RES_W-1:0] decided;

  assign bit_mask = RES_W'(1) << idx;
  // Input above the trial keeps the bit, so saturation falls out
  assign decided  = cmp_hi ? dac_code : (dac_code & ~bit_mask);
  assign busy     = (state != ACR_SAR_IDLE);

  // ==========================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ACR_SAR_IDLE;
      idx      <= 4'h0;
      lat      <= 2'h0;
      dac_code <= '0;
      result   <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!run) begin
        state <= ACR_SAR_IDLE;
      end else if (restart) begin
        state <= ACR_SAR_SAMPLE;
      end else begin
        unique case (state)
          ACR_SAR_IDLE: begin
            state <= ACR_SAR_SAMPLE;
          end
          ACR_SAR_SAMPLE: begin
            if (tick) begin
              dac_code <= RES_W'(1) << SAR_MSB;
              idx      <= SAR_MSB;
              lat      <= 2'h0;
              state    <= ACR_SAR_TRIAL;
            end
          end
          ACR_SAR_TRIAL: begin
            // Comparator lags the code by its synchroniser
            if (lat != CMP_WAIT) begin
              lat <= lat + 2'h1;
            end else if (tick) begin
              lat <= 2'h0;
              if (idx == 4'h0) begin
                result <= decided;
                done   <= 1'b1;
                state  <= ACR_SAR_SAMPLE;
              end else begin
                dac_code <= decided | (bit_mask >> 1);
                idx      <= idx - 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : acr_sar
`default_nettype wire

// [acr_top_properties.sv]
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acr_top_properties
  import acr_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic [11:0]      paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             halt_mode,
  input wire logic             wait_mode,
  input wire logic             converter_power,
  input wire logic [CH_W-1:0]  mux_channel,
  input wire logic             amp_path_select,
  input wire logic             amp_offset_cal,
  input wire logic [RES_W-1:0] dac_code
);
  // ==========================================================
  // Committed writes
  logic       wr;
  logic       csr_wr;
  logic       drl_wr;
  logic [7:0] last_csr;
  logic [7:0] last_drl;
  assign wr     = psel && penable && pready && pwrite;
  assign csr_wr = wr && paddr == {CSR_IDX, 2'b00};
  assign drl_wr = wr && paddr == {DRL_IDX, 2'b00};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_csr <= 8'h00;
    else if (csr_wr)
      last_csr <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_drl <= 8'h00;
    else if (drl_wr)
      last_drl <= pwdata[7:0];
  end
  // ==========================================================
  // Properties
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_halt_power: assert property (halt_mode |=> !converter_power)
    else $error("converter powered in halt");
  // Previous cycle excluded: a write may still be landing
  chk_wait_keeps: assert property (wait_mode && converter_power
    && !halt_mode && !psel && !$past(psel) |=> converter_power)
    else $error("wait mode disturbed converter");
  chk_off_power: assert property (csr_wr && !pwdata[5]
    |-> ##[1:2] !converter_power)
    else $error("converter still powered after off");
  chk_on_power: assert property (csr_wr && pwdata[5] && !halt_mode
    |-> ##[1:2] (converter_power || halt_mode || $past(halt_mode)))
    else $error("converter not powered after on");
  chk_chan_follow: assert property (csr_wr
    |-> ##[1:2] mux_channel == last_csr[3:0])
    else $error("mux channel differs from field");
  chk_amp_path: assert property (drl_wr
    |-> ##[1:2] amp_path_select == last_drl[2])
    else $error("amplifier path differs from field");
  chk_amp_cal: assert property (drl_wr
    |-> ##[1:2] amp_offset_cal == last_drl[4])
    else $error("calibration differs from field");
  chk_drl_zero: assert property (psel && pready && !pwrite
    && paddr == {DRL_IDX, 2'b00} |-> prdata[7:5] == 3'b000)
    else $error("low register top bits not zero");
  chk_sar_runs: assert property (converter_power
    |-> ##[1:40] ($changed(dac_code) || !converter_power))
    else $error("converter powered but idle");
endmodule : acr_top_properties

bind acr_top acr_top_properties u_props (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pready, .prdata, .halt_mode, .wait_mode,
  .converter_power, .mux_channel, .amp_path_select, .amp_offset_cal,
  .dac_code);
`default_nettype wire

// [acr_analog_model.sv]
// Behavioural analog core: input mux, amplifier and comparator
`timescale 1ns/10ps
`default_nettype none
module acr_analog_model
  import acr_pkg::*;
(
  input wire logic             pclk,
  input wire logic             converter_power,
  input wire logic [CH_W-1:0]  mux_channel,
  input wire logic             amp_path_select,
  input wire logic             amp_offset_cal,
  input wire logic [RES_W-1:0] dac_code,
  output logic                 cmp_above
);
  logic             flip = 1'b0;
  logic [RES_W-1:0] level;
  logic             over;
  logic             under;
  // Unpowered comparator gives no stable answer
  always @(posedge pclk) flip <= !flip;
  // Amplifier modelled at unity gain, zero volts under calibration
  assign under = mux_channel == 4'h1
    || (amp_path_select && amp_offset_cal);
  assign over  = mux_channel == 4'h0;
  assign level = {mux_channel, 6'h25};
  assign cmp_above = !converter_power ? flip
    : under ? 1'b0
    : over ? 1'b1
    : level >= dac_code;
endmodule : acr_analog_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import acr_pkg::*;
;
  localparam logic [11:0] A_CSR = {CSR_IDX, 2'b00};
  localparam logic [11:0] A_DRH = {DRH_IDX, 2'b00};
  localparam logic [11:0] A_DRL = {DRL_IDX, 2'b00};
  localparam logic [11:0] A_IST = {IST_IDX, 2'b00};
  localparam logic [11:0] A_MSK = {IMSK_IDX, 2'b00};
  localparam logic [11:0] A_STA = {STAT_IDX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        halt_mode, wait_mode, cmp_above, converter_power, er;
  logic        amp_path_select, amp_offset_cal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  mux_channel;
  logic [9:0]  dac_code;
  int          miscompares, n_checks;
  acr_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .prdata, .pslverr, .halt_mode, .wait_mode, .cmp_above,
    .converter_power, .mux_channel, .amp_path_select, .amp_offset_cal,
    .dac_code, .irq);
  acr_analog_model u_ana (.pclk, .converter_power, .mux_channel,
    .amp_path_select, .amp_offset_cal, .dac_code, .cmp_above);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = !pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) chk("pready", 32'h1, 32'h0);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(A_CSR, 1'b0, 8'h00);
      n++;
    end while (rv[7] !== 1'b1 && n < 200);
    chk("done", 32'h1, {31'h0, rv[7]});
  endtask : wait_done
  task automatic chk_irq(input logic e);
    // Interrupt output is registered on the same edge as its status
    repeat (2) @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq
  // Ten trials of four cycles plus one tick of sampling per conversion
  task automatic chk_rate(input int t);
    logic [9:0] prev;
    int         n;
    int         k;
    prev = dac_code;
    n = 0;
    k = 0;
    // A load of the top trial bit marks each conversion start
    while (k < 2 && n < 200) begin
      @(posedge pclk);
      n++;
      if (dac_code == 10'h200 && prev != 10'h200) begin
        k++;
        if (k == 1) n = 0;
      end
      prev = dac_code;
    end
    chk("rate", 40 + t, n);
  endtask : chk_rate
  task automatic conv(input logic [3:0] ch, input logic [7:0] drl,
                      input logic sp);
    logic [9:0] e;
    e = (ch == 4'h0) ? 10'h3FF : {ch, 6'h25};
    if (ch == 4'h1 || drl[4]) e = 10'h000;
    apb(A_DRL, 1'b1, drl);
    apb(A_CSR, 1'b1, {1'b0, sp, 2'b10, ch});
    repeat (2) @(negedge pclk);
    chk("mux", {28'h0, ch}, {28'h0, mux_channel});
    chk("power", 32'h1, {31'h0, converter_power});
    wait_done();
    apb(A_DRL, 1'b0, 8'h00);
    chk("low", {27'h0, drl[4:2], e[1:0]}, rv);
    apb(A_DRH, 1'b0, 8'h00);
    chk("high", {24'h0, e[9:2]}, rv);
    apb(A_CSR, 1'b0, 8'h00);
    chk("csr", {24'h0, 1'b0, sp, 2'b10, ch}, rv);
    chk_rate(drl[3] ? 4 : (sp ? 1 : 2));
  endtask : conv
  initial begin
    {presetn, psel, penable, pwrite, halt_mode, wait_mode} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(A_CSR, 1'b0, 8'h00);
    chk("csr reset", 32'h0, rv);
    apb(A_DRL, 1'b0, 8'h00);
    chk("drl reset", 32'h0, rv & 32'hFFFF_FFFC);
    apb(12'h100, 1'b0, 8'h00);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(A_MSK, 1'b1, 8'h01);
    // All four slow and speed bit combinations (three clock rates), every channel
    for (int i = 0; i < 10; i++)
      conv(i[3:0], {4'h0, i[1], 3'h0}, i[0]);
    chk_irq(1'b1);
    apb(A_CSR, 1'b1, 8'h00);
    repeat (150) @(posedge pclk);
    chk("off", 32'h0, {31'h0, converter_power});
    apb(A_CSR, 1'b0, 8'h00);
    chk("off csr", 32'h0, rv);
    apb(A_IST, 1'b0, 8'h00);
    chk("status", 32'h3, rv);
    apb(A_IST, 1'b1, 8'h01);
    apb(A_IST, 1'b0, 8'h00);
    chk("w1c", 32'h2, rv);
    chk_irq(1'b0);
    apb(A_MSK, 1'b1, 8'h02);
    chk_irq(1'b1);
    apb(A_IST, 1'b1, 8'h02);
    chk_irq(1'b0);
    conv(4'h0, 8'h1C, 1'b0);
    chk("amp", 32'h3,
        {30'h0, amp_path_select, amp_offset_cal});
    conv(4'h2, 8'h00, 1'b1);
    apb(A_IST, 1'b1, 8'h03);
    apb(A_CSR, 1'b1, 8'h62);
    wait_done();
    apb(A_IST, 1'b0, 8'h00);
    chk("no abort", 32'h1, rv);
    apb(A_CSR, 1'b1, 8'h67);
    apb(A_IST, 1'b0, 8'h00);
    chk("abort", 32'h3, rv);
    apb(A_CSR, 1'b0, 8'h00);
    chk("restart", 32'h67, rv);
    wait_mode <= 1'b1;
    conv(4'h9, 8'h00, 1'b0);
    apb(A_STA, 1'b0, 8'h00);
    chk("wait state", 32'h8, rv & 32'hE);
    wait_mode <= 1'b0;
    halt_mode <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("halt power", 32'h0, {31'h0, converter_power});
    apb(A_CSR, 1'b1, 8'h29);
    repeat (200) @(posedge pclk);
    apb(A_CSR, 1'b0, 8'h00);
    chk("halt csr", 32'h29, rv);
    apb(A_STA, 1'b0, 8'h00);
    chk("halt state", 32'h2, rv & 32'h6);
    halt_mode <= 1'b0;
    apb(A_STA, 1'b0, 8'h00);
    chk("settling", 32'h4, rv & 32'h6);
    repeat (SETTLE_CYC) @(posedge pclk);
    apb(A_STA, 1'b0, 8'h00);
    chk("settled", 32'h0, rv & 32'h6);
    wait_done();
    results();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    results();
  end
endmodule : tb_top
`default_nettype wire
